// ### logic/acw_pkg.sv
package acw_pkg;

	// ****************************************
	// Frame layout
	// ****************************************
	localparam logic [7:0] FUNC_WRITE_ONE = 8'h06;
	localparam logic [7:0] ADDR_BROADCAST = 8'h00;
	localparam logic [7:0] ADDR_OFFSET = 8'h01;
	localparam logic [3:0] FRAME_BYTES = 4'h8;
	localparam logic [3:0] IDX_SLAVE = 4'h0;
	localparam logic [3:0] IDX_FUNC = 4'h1;
	localparam logic [3:0] IDX_ADDR_HI = 4'h2;
	localparam logic [3:0] IDX_ADDR_LO = 4'h3;
	localparam logic [3:0] IDX_DATA_HI = 4'h4;
	localparam logic [3:0] IDX_DATA_LO = 4'h5;

	// ****************************************
	// Register map and fields
	// ****************************************
	localparam logic [15:0] REG_CTL_ONE = 16'h0d00;
	localparam logic [15:0] REG_CTL_TWO = 16'h0d01;
	localparam logic [15:0] REG_POS_NUM = 16'h0d03;
	localparam logic [15:0] REG_POS_MOVE = 16'h9800;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam int BIT_SERVO = 12;
	localparam int BIT_HOME = 4;
	localparam int BIT_START = 3;

	// ****************************************
	// Check code
	// ****************************************
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [15:0] CRC_RESIDUE = 16'h0000;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int BAUD_DEFAULT = 9600;
	localparam int CHAR_BITS = 11;
	localparam int SILENT_CHARS_X10 = 35;
	localparam int BIT_CYC_DEFAULT = CLK_HZ / BAUD_DEFAULT;
	localparam int SILENT_CYC_DEFAULT = (BIT_CYC_DEFAULT * CHAR_BITS * SILENT_CHARS_X10 + 9) / 10;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_RECV = 4'b0010,
		ST_CHECK = 4'b0100,
		ST_SEND = 4'b1000
	} acw_state_t;

endpackage : acw_pkg

// ### logic/acw_crc_if.sv
`timescale 1ns/10ps
`default_nettype none
interface acw_crc_if;
	logic clr;
	logic en;
	logic [7:0] data;
	logic [15:0] crc;
	modport user(output clr, output en, output data, input crc);
	modport engine(input clr, input en, input data, output crc);
endinterface : acw_crc_if
`default_nettype wire

// ### logic/acw_crc.sv
`timescale 1ns/10ps
`default_nettype none
module acw_crc
	import acw_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	acw_crc_if.engine crc_port
);

	function automatic logic [15:0] acw_crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
		begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : acw_crc_byte

	logic [15:0] crc_ff;
	wire logic [15:0] seed = crc_port.clr ? CRC_INIT : crc_ff;
	wire logic [15:0] nxt_crc = crc_port.en ? acw_crc_byte(seed, crc_port.data) : seed;

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			crc_ff <= CRC_INIT;
		else
			crc_ff <= nxt_crc;
	end

	assign crc_port.crc = crc_ff;

endmodule : acw_crc
`default_nettype wire

// ### logic/acw_top.sv
`timescale 1ns/10ps
`default_nettype none
module acw_top
	import acw_pkg::*;
#(
	parameter int BIT_CYC = BIT_CYC_DEFAULT,
	parameter int SILENT_CYC = SILENT_CYC_DEFAULT
)
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic serial_rx,
	output logic serial_tx,
	input wire logic [3:0] axis_number,
	input wire logic parallel_io_switch_state,
	input wire logic [15:0] parallel_io_ctl,
	input wire logic [15:0] parallel_io_pos,
	output logic [15:0] device_control_one,
	output logic [15:0] device_control_two,
	output logic [15:0] position_select,
	output logic [15:0] position_movement,
	output logic servo_on,
	output logic home_request,
	output logic move_start,
	output logic [15:0] move_position
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	localparam int SYNC_W = 38;
	// Line idle high, switch and pins low: a preset of ones would copy all-ones pins and fake a strobe rise
	localparam logic [SYNC_W-1:0] SYNC_RST = {1'b1, {(SYNC_W-1){1'b0}}};
	logic [SYNC_W-1:0] sync1_ff;
	logic [SYNC_W-1:0] sync2_ff;

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			sync1_ff <= SYNC_RST;
			sync2_ff <= SYNC_RST;
		end
		else
		begin
			sync1_ff <= {serial_rx, parallel_io_switch_state, axis_number, parallel_io_ctl, parallel_io_pos};
			sync2_ff <= sync1_ff;
		end
	end

	wire logic rx_line = sync2_ff[37];
	// Switch high selects parallel commands
	wire logic par_mode = sync2_ff[36];
	wire logic [3:0] axis_sync = sync2_ff[35:32];
	wire logic [15:0] par_ctl = sync2_ff[31:16];
	wire logic [15:0] par_pos = sync2_ff[15:0];

	// ****************************************
	// Receiver
	// ****************************************
	logic rx_busy_ff;
	logic [15:0] rx_tick_ff;
	logic [3:0] rx_bit_ff;
	logic [7:0] rx_shift_ff;
	logic rx_vld_ff;

	wire logic rx_tick_zero = rx_tick_ff == 16'h0000;
	wire logic rx_start = !rx_busy_ff && !rx_line;

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_busy_ff <= 1'b0;
			rx_tick_ff <= 16'h0000;
			rx_bit_ff <= 4'h0;
			rx_shift_ff <= 8'h00;
			rx_vld_ff <= 1'b0;
		end
		else
		begin
			rx_vld_ff <= 1'b0;
			if (rx_start)
			begin
				// Sample mid-bit to ride out edge jitter
				rx_busy_ff <= 1'b1;
				rx_tick_ff <= 16'(BIT_CYC / 2);
				rx_bit_ff <= 4'h0;
			end
			else if (rx_busy_ff && !rx_tick_zero)
				rx_tick_ff <= rx_tick_ff - 16'h0001;
			else if (rx_busy_ff)
			begin
				rx_tick_ff <= 16'(BIT_CYC - 1);
				rx_bit_ff <= rx_bit_ff + 4'h1;
				if (rx_bit_ff == 4'h0 && rx_line)
					rx_busy_ff <= 1'b0;
				else if (rx_bit_ff == 4'h9)
				begin
					rx_busy_ff <= 1'b0;
					rx_vld_ff <= rx_line;
				end
				else if (rx_bit_ff != 4'h0)
					rx_shift_ff <= {rx_line, rx_shift_ff[7:1]};
			end
		end
	end

	// ****************************************
	// Transmitter
	// ****************************************
	logic tx_busy_ff;
	logic [15:0] tx_tick_ff;
	logic [3:0] tx_bits_ff;
	logic [8:0] tx_shift_ff;
	logic tx_pin_ff;
	logic [3:0] tx_idx_ff;
	acw_state_t state_ff;
	logic [7:0] frame_ff [FRAME_BYTES];

	wire logic tx_load = state_ff == ST_SEND && !tx_busy_ff && tx_idx_ff != FRAME_BYTES;
	wire logic tx_tick_zero = tx_tick_ff == 16'h0000;

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_busy_ff <= 1'b0;
			tx_tick_ff <= 16'h0000;
			tx_bits_ff <= 4'h0;
			tx_shift_ff <= 9'h1ff;
			tx_pin_ff <= 1'b1;
		end
		else if (tx_load)
		begin
			tx_busy_ff <= 1'b1;
			tx_tick_ff <= 16'(BIT_CYC - 1);
			tx_bits_ff <= 4'h9;
			tx_shift_ff <= {1'b1, frame_ff[tx_idx_ff[2:0]]};
			tx_pin_ff <= 1'b0;
		end
		else if (tx_busy_ff && !tx_tick_zero)
			tx_tick_ff <= tx_tick_ff - 16'h0001;
		else if (tx_busy_ff)
		begin
			tx_tick_ff <= 16'(BIT_CYC - 1);
			if (tx_bits_ff == 4'h0)
				tx_busy_ff <= 1'b0;
			else
			begin
				tx_pin_ff <= tx_shift_ff[0];
				tx_shift_ff <= {1'b1, tx_shift_ff[8:1]};
				tx_bits_ff <= tx_bits_ff - 4'h1;
			end
		end
	end

	// ****************************************
	// Silent interval timer
	// ****************************************
	logic [19:0] sil_ff;
	logic quiet_ff;

	// Own transmission also restarts the silence, so replies get their gap too
	wire logic line_busy = rx_busy_ff || !rx_line || tx_busy_ff;
	wire logic sil_hit = sil_ff == 20'(SILENT_CYC);

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			sil_ff <= 20'h00000;
		else if (line_busy)
			sil_ff <= 20'h00000;
		else if (!sil_hit)
			sil_ff <= sil_ff + 20'h00001;
	end

	// ****************************************
	// Frame collection and check
	// ****************************************
	logic [3:0] cnt_ff;
	logic over_ff;
	acw_crc_if crc_bus();

	acw_crc u_crc
	(
		.clk_sys(clk_sys),
		.nrst(nrst),
		.crc_port(crc_bus.engine)
	);

	wire logic frame_begin = state_ff == ST_IDLE && rx_vld_ff && quiet_ff;
	wire logic frame_room = cnt_ff != FRAME_BYTES;
	wire logic store_byte = frame_begin || (state_ff == ST_RECV && rx_vld_ff && frame_room);
	wire logic [3:0] store_idx = frame_begin ? 4'h0 : cnt_ff;

	assign crc_bus.clr = frame_begin;
	assign crc_bus.en = store_byte;
	assign crc_bus.data = rx_shift_ff;

	wire logic [7:0] own_addr = {4'h0, axis_sync} + ADDR_OFFSET;
	wire logic [7:0] slave_byte = frame_ff[IDX_SLAVE[2:0]];
	wire logic [15:0] wr_addr = {frame_ff[IDX_ADDR_HI[2:0]], frame_ff[IDX_ADDR_LO[2:0]]};
	wire logic [15:0] wr_data = {frame_ff[IDX_DATA_HI[2:0]], frame_ff[IDX_DATA_LO[2:0]]};
	wire logic is_bcast = slave_byte == ADDR_BROADCAST;
	wire logic slave_ok = slave_byte == own_addr || is_bcast;
	wire logic len_ok = cnt_ff == FRAME_BYTES && !over_ff;
	wire logic crc_ok = crc_bus.crc == CRC_RESIDUE;
	wire logic func_ok = frame_ff[IDX_FUNC[2:0]] == FUNC_WRITE_ONE;
	wire logic hit_one = wr_addr == REG_CTL_ONE;
	wire logic hit_two = wr_addr == REG_CTL_TWO;
	wire logic hit_num = wr_addr == REG_POS_NUM;
	wire logic hit_move = wr_addr == REG_POS_MOVE;
	wire logic addr_ok = hit_one || hit_two || hit_num || hit_move;
	// Parallel mode turns a serial write into an invalid one
	wire logic wr_ok = state_ff == ST_CHECK && len_ok && crc_ok && func_ok && slave_ok && addr_ok && !par_mode;
	// Invalid queries and broadcasts get silence, never an echo
	wire logic do_reply = wr_ok && !is_bcast;

	always_ff @(posedge clk_sys)
	begin
		if (store_byte)
			frame_ff[store_idx[2:0]] <= rx_shift_ff;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			state_ff <= ST_IDLE;
			cnt_ff <= 4'h0;
			over_ff <= 1'b0;
			quiet_ff <= 1'b0;
			tx_idx_ff <= 4'h0;
		end
		else
		begin
			unique case (state_ff)
				ST_IDLE:
				begin
					if (sil_hit)
						quiet_ff <= 1'b1;
					if (frame_begin)
					begin
						state_ff <= ST_RECV;
						cnt_ff <= 4'h1;
						over_ff <= 1'b0;
						quiet_ff <= 1'b0;
					end
				end
				ST_RECV:
				begin
					if (rx_vld_ff && frame_room)
						cnt_ff <= cnt_ff + 4'h1;
					else if (rx_vld_ff)
						over_ff <= 1'b1;
					if (sil_hit)
						state_ff <= ST_CHECK;
				end
				ST_CHECK:
				begin
					tx_idx_ff <= 4'h0;
					quiet_ff <= !do_reply;
					state_ff <= do_reply ? ST_SEND : ST_IDLE;
				end
				ST_SEND:
				begin
					if (tx_load)
						tx_idx_ff <= tx_idx_ff + 4'h1;
					else if (!tx_busy_ff && tx_idx_ff == FRAME_BYTES)
						state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Control command registers
	// ****************************************
	logic [15:0] ctl_one_ff;
	logic [15:0] ctl_two_ff;
	logic [15:0] pos_num_ff;
	logic [15:0] pos_move_ff;
	logic home_ff;
	logic start_ff;
	logic [15:0] move_pos_ff;

	wire logic wr_one = wr_ok && hit_one;
	wire logic wr_move = wr_ok && hit_move;
	wire logic [15:0] nxt_ctl_one = par_mode ? par_ctl : (wr_one ? wr_data : ctl_one_ff);
	wire logic [15:0] nxt_ctl_two = (wr_ok && hit_two) ? wr_data : ctl_two_ff;
	wire logic [15:0] nxt_pos_num = par_mode ? par_pos : ((wr_ok && hit_num) ? wr_data : pos_num_ff);
	wire logic [15:0] nxt_pos_move = wr_move ? wr_data : pos_move_ff;
	// A serial write re-arms home each time; parallel inputs need a rising bit
	wire logic home_written = wr_one || (par_mode && !ctl_one_ff[BIT_HOME]);
	// Servo must already be on before this write for home to count
	wire logic nxt_home = home_written && nxt_ctl_one[BIT_HOME] && ctl_one_ff[BIT_SERVO] && nxt_ctl_one[BIT_SERVO];
	wire logic strobe_rise = !ctl_one_ff[BIT_START] && nxt_ctl_one[BIT_START];
	wire logic nxt_start = strobe_rise || wr_move;
	wire logic [15:0] nxt_move_pos = wr_move ? wr_data : (strobe_rise ? nxt_pos_num : move_pos_ff);

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			ctl_one_ff <= REG_RESET;
			ctl_two_ff <= REG_RESET;
			pos_num_ff <= REG_RESET;
			pos_move_ff <= REG_RESET;
			home_ff <= 1'b0;
			start_ff <= 1'b0;
			move_pos_ff <= REG_RESET;
		end
		else
		begin
			ctl_one_ff <= nxt_ctl_one;
			ctl_two_ff <= nxt_ctl_two;
			pos_num_ff <= nxt_pos_num;
			pos_move_ff <= nxt_pos_move;
			home_ff <= nxt_home;
			start_ff <= nxt_start;
			move_pos_ff <= nxt_move_pos;
		end
	end

	assign serial_tx = tx_pin_ff;
	assign device_control_one = ctl_one_ff;
	assign device_control_two = ctl_two_ff;
	assign position_select = pos_num_ff;
	assign position_movement = pos_move_ff;
	assign servo_on = ctl_one_ff[BIT_SERVO];
	assign home_request = home_ff;
	assign move_start = start_ff;
	assign move_position = move_pos_ff;

endmodule : acw_top
`default_nettype wire

// ### verif/acw_host.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Serial master stand-in
// ****************************************
module acw_host #(parameter int BIT_CYC = 8)
(
	input wire logic clk_sys,
	output logic rx_line,
	input wire logic tx_line
);
	logic [7:0] got_q[$];
	logic [7:0] sent_q[$];
	initial rx_line = 1'b1;
	task automatic put_byte(input logic [7:0] b);
		logic [9:0] sh;
		sh = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(negedge clk_sys) rx_line <= sh[i];
			repeat (BIT_CYC - 1) @(negedge clk_sys);
		end
	endtask : put_byte
	task automatic send(input logic [7:0] f [6], input logic bad);
		logic [15:0] crc;
		crc = 16'hffff;
		sent_q.delete();
		got_q.delete();
		for (int i = 0; i < 6; i++)
		begin
			sent_q.push_back(f[i]);
			crc ^= {8'h00, f[i]};
			for (int k = 0; k < 8; k++)
				crc = crc[0] ? (crc >> 1) ^ 16'ha001 : crc >> 1;
		end
		// One flipped check bit gives a frame the slave must drop
		crc ^= {15'h0000, bad};
		sent_q.push_back(crc[7:0]);
		sent_q.push_back(crc[15:8]);
		foreach (sent_q[i])
			put_byte(sent_q[i]);
	endtask : send
	initial
	forever
	begin : rx_loop
		logic [7:0] b;
		@(negedge tx_line);
		repeat (BIT_CYC / 2) @(posedge clk_sys);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT_CYC) @(posedge clk_sys);
			b[i] = tx_line;
		end
		repeat (BIT_CYC) @(posedge clk_sys);
		got_q.push_back(b);
	end
endmodule : acw_host
`default_nettype wire

// ### verif/acw_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module acw_top_asserts
	import acw_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic serial_rx,
	input wire logic serial_tx,
	input wire logic [3:0] axis_number,
	input wire logic parallel_io_switch_state,
	input wire logic [15:0] parallel_io_ctl,
	input wire logic [15:0] parallel_io_pos,
	input wire logic [15:0] device_control_one,
	input wire logic [15:0] device_control_two,
	input wire logic [15:0] position_select,
	input wire logic [15:0] position_movement,
	input wire logic servo_on,
	input wire logic home_request,
	input wire logic move_start,
	input wire logic [15:0] move_position
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	a_servo_bit: assert property (servo_on == device_control_one[BIT_SERVO])
		else $error("servo flag differs from control bit");
	a_home_cause: assert property (home_request |-> device_control_one[BIT_HOME] && $past(servo_on))
		else $error("home request without servo on");
	a_pulse_single: assert property ((home_request || move_start) |=> !home_request && !move_start)
		else $error("command pulse longer than one cycle");
	a_start_rise: assert property ($rose(device_control_one[BIT_START]) |-> move_start
		&& move_position == position_select)
		else $error("start strobe rise gave no move");
	a_pos_move: assert property ($changed(position_movement) |-> move_start
		&& move_position == position_movement)
		else $error("direct position write gave no move");
	a_move_cause: assert property (move_start |-> $rose(device_control_one[BIT_START])
		|| move_position == position_movement)
		else $error("move started without cause");
	a_parallel_copy: assert property ((parallel_io_switch_state && $stable(parallel_io_ctl)
		&& $stable(parallel_io_pos)) [*5] |-> device_control_one == parallel_io_ctl
		&& position_select == parallel_io_pos)
		else $error("control registers ignore parallel pins");
	a_serial_locked: assert property (parallel_io_switch_state [*5] |-> $stable(device_control_two)
		&& $stable(position_movement))
		else $error("register changed in parallel mode");
endmodule : acw_top_asserts
bind acw_top acw_top_asserts u_asserts (.clk_sys, .nrst, .serial_rx, .serial_tx, .axis_number,
	.parallel_io_switch_state, .parallel_io_ctl, .parallel_io_pos, .device_control_one,
	.device_control_two, .position_select, .position_movement, .servo_on, .home_request,
	.move_start, .move_position);
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Register write bench
// ****************************************
module tb_top
	import acw_pkg::*;
;
	localparam int BC = 8;
	localparam int SC = 400;
	logic clk_sys, nrst, serial_rx, serial_tx, parallel_io_switch_state;
	logic servo_on, home_request, move_start;
	logic [3:0] axis_number;
	logic [15:0] parallel_io_ctl, parallel_io_pos, device_control_one, device_control_two;
	logic [15:0] position_select, position_movement, move_position;
	int miscompares, comparisons, seed, n_home, n_move, s_home, s_move, e_mv, ax, d;
	int m [4];
	acw_top #(.BIT_CYC(BC), .SILENT_CYC(SC)) DUT (.clk_sys, .nrst, .serial_rx, .serial_tx,
		.axis_number, .parallel_io_switch_state, .parallel_io_ctl, .parallel_io_pos,
		.device_control_one, .device_control_two, .position_select, .position_movement,
		.servo_on, .home_request, .move_start, .move_position);
	acw_host #(.BIT_CYC(BC)) HOST (.clk_sys, .rx_line(serial_rx), .tx_line(serial_tx));
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Mid-cycle sampling keeps the pulse count clear of the launching edge
	always @(negedge clk_sys)
	begin
		if (home_request === 1'b1)
			s_home++;
		if (move_start === 1'b1)
			s_move++;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	task automatic regs();
		check(device_control_one, m[0]);
		check(device_control_two, m[1]);
		check(position_select, m[2]);
		check(position_movement, m[3]);
		check(servo_on, m[0][12]);
		check(s_home, n_home);
		check(s_move, n_move);
		check(move_position, e_mv);
	endtask : regs
	task automatic wr(input int sa, input int fc, input int ad, input int dt, input logic bad);
		logic [7:0] f [6];
		logic ok;
		f = '{sa[7:0], fc[7:0], ad[15:8], ad[7:0], dt[15:8], dt[7:0]};
		ok = !bad && fc == 6 && (sa == 0 || sa == ax) && !parallel_io_switch_state
			&& (ad == REG_CTL_ONE || ad == REG_CTL_TWO || ad == REG_POS_NUM || ad == REG_POS_MOVE);
		if (ok && ad == REG_CTL_ONE)
		begin
			n_home += dt[4] && dt[12] && m[0][12];
			if (dt[3] && !m[0][3])
			begin
				n_move++;
				e_mv = m[2];
			end
		end
		if (ok && ad == REG_POS_MOVE)
		begin
			n_move++;
			e_mv = dt;
		end
		if (ok)
			m[ad == REG_CTL_ONE ? 0 : ad == REG_CTL_TWO ? 1 : ad == REG_POS_NUM ? 2 : 3] = dt;
		HOST.send(f, bad);
		// Covers reply plus the silence owed before the next query
		repeat (1700) @(negedge clk_sys);
		check(HOST.got_q.size(), ok && sa != 0 ? 8 : 0);
		foreach (HOST.got_q[i])
			check(HOST.got_q[i], HOST.sent_q[i]);
		regs();
	endtask : wr
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		miscompares++;
		complete_run();
	end
	initial
	begin
		seed = 32'h298f;
		nrst = 1'b0;
		parallel_io_switch_state = 1'b0;
		parallel_io_ctl = 16'h0000;
		parallel_io_pos = 16'h0000;
		axis_number = 4'($random(seed));
		repeat (4) @(negedge clk_sys);
		nrst = 1'b1;
		ax = axis_number + 1;
		repeat (SC + 20) @(negedge clk_sys);
		regs();
		wr(ax, 6, REG_CTL_ONE, 16'h1000, 0);
		wr(ax, 6, REG_CTL_ONE, 16'h1010, 0);
		wr(ax, 6, REG_CTL_ONE, 16'h0000, 0);
		wr(ax, 6, REG_CTL_ONE, 16'h1010, 0);
		wr(ax, 6, REG_POS_NUM, $random(seed) & 16'hffff, 0);
		wr(ax, 6, REG_CTL_ONE, 16'h1008, 0);
		d = $random(seed) & 16'hffff;
		repeat (2) wr(ax, 6, REG_POS_MOVE, d, 0);
		wr(ax, 6, REG_CTL_TWO, $random(seed) & 16'hffff, 0);
		wr(0, 6, REG_CTL_TWO, $random(seed) & 16'hffff, 0);
		for (int i = 0; i < 4; i++)
			wr(i == 2 ? ax + 1 : ax, i == 1 ? 5 : 6, i == 3 ? 16'h0d02 : REG_CTL_TWO,
				$random(seed) & 16'hffff, i == 0);
		@(negedge clk_sys);
		parallel_io_switch_state = 1'b1;
		// Bits 3 and 4 cleared so the pins raise no command pulse
		parallel_io_ctl = 16'($random(seed)) & 16'hffe7;
		parallel_io_pos = 16'($random(seed));
		repeat (8) @(negedge clk_sys);
		check(device_control_one, parallel_io_ctl);
		check(position_select, parallel_io_pos);
		m[0] = parallel_io_ctl;
		m[2] = parallel_io_pos;
		// Pins raise servo first, then home and strobe in one step
		parallel_io_ctl = 16'h1000;
		repeat (8) @(negedge clk_sys);
		parallel_io_ctl = 16'h1018;
		m[0] = 16'h1018;
		n_home++;
		n_move++;
		e_mv = m[2];
		repeat (8) @(negedge clk_sys);
		wr(ax, 6, REG_CTL_TWO, 16'h5a5a, 0);
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
